// >>> rtl/lsq_sequencer.sv
// Overview of operation
// - Voltage list holds up to 100 setpoints
// - End-of-step flag list, up to 100
// - Pulse only for steps with flag set
// - Start flag pulses as dwell begins
// - Lengths match or equal one
// - Each load write sets one entry
// - Steps run in index order
// - Reset leaves one cleared flag each
// - List reset command leaves one minimum voltage entry
// - Length query returns entry counts
// - Flag readback gives zero or one
// - No channel given uses selected channel
// - Dwell-paced advances when dwell expires
// - Trigger-paced waits, ignores dwell triggers
// - Dwell 0.01 to 3600 s, 1 ms
// - Abort or no-hold restores prior setting
module lsq_sequencer #(
    parameter int STEPS  = 100,
    parameter int MS_CYC = lsq_pkg::CYC_PER_MS
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        reset,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Other inputs
    input  wire logic [15:0] idle_volt,
    input  wire logic        ext_trig,
    // Output and triggers
    output logic      [15:0] volt_out_ff,
    output logic             step_trig_ff,
    output logic             running_ff
);
    // ==========================================================
    // Elaboration checks; step counters are seven bits wide
    if (STEPS < 1 || STEPS > 127) begin : g_bad_steps
        $error("STEPS out of range");
    end
    // A zero-length millisecond would never tick
    if (MS_CYC < 1) begin : g_bad_ms
        $error("MS_CYC out of range");
    end

    // ==========================================================
    // List storage, one channel
    logic [15:0] volt_mem [STEPS];           // Voltage list
    logic [STEPS-1:0] start_flags_ff;        // step_start_trigger_list
    logic [STEPS-1:0] end_flags_ff;          // step_end_trigger_list
    logic [6:0]  vlen_ff, slen_ff, elen_ff;  // Stored lengths
    logic [21:0] dwell_ms_ff;                // Dwell in ms
    logic        paced_ff, hold_ff;          // trigger_paced, hold_last_step
    logic [6:0]  rd_idx_ff;                  // Readback index
    logic [31:0] prdata_ff;
    logic        pready_ff, pslverr_ff;

    // Synchronised external trigger
    // Only the second flop is read; the first may be metastable
    logic trig_m_ff, trig_s_ff;
    always_ff @(posedge clock) begin
        trig_m_ff <= reset ? 1'b0 : ext_trig;
        trig_s_ff <= reset ? 1'b0 : trig_m_ff;
    end

    // Bus decode; reads are captured at the first access edge so data stands with pready
    wire logic acc  = psel && penable && !pready_ff;
    // Writes take effect only at the edge where pready is seen high
    wire logic done = psel && penable && pready_ff;
    wire logic wr   = done && pwrite;
    wire logic [6:0] ld_idx = pwdata[lsq_pkg::LOAD_IDX_LSB +: 7];

    // Entry for a step; a single-entry list serves all steps
    function automatic logic [6:0] pick(input logic [6:0] len, input logic [6:0] i);
        pick = (len == 7'd1) ? 7'd0 : i;
    endfunction

    // Longest list length
    function automatic logic [6:0] max3(input logic [6:0] a, b, c);
        logic [6:0] m;
        m = (a > b) ? a : b;
        max3 = (m > c) ? m : c;
    endfunction

    wire logic [6:0] run_len = max3(vlen_ff, slen_ff, elen_ff);
    // Valid only with equal lengths or lengths of one
    wire logic valid = (vlen_ff == run_len || vlen_ff == 7'd1) &&
                       (slen_ff == run_len || slen_ff == 7'd1) &&
                       (elen_ff == run_len || elen_ff == 7'd1);
    wire logic dwell_ok = dwell_ms_ff >= 22'(lsq_pkg::DWELL_MIN_MS) &&
                          dwell_ms_ff <= 22'(lsq_pkg::DWELL_MAX_MS);

    wire logic cmd_start = wr && paddr == lsq_pkg::CTRL_OFF && pwdata[lsq_pkg::CTRL_START_BIT];
    wire logic cmd_abort = wr && paddr == lsq_pkg::CTRL_OFF && pwdata[lsq_pkg::CTRL_ABORT_BIT];
    wire logic cmd_rst   = wr && paddr == lsq_pkg::CTRL_OFF && pwdata[lsq_pkg::CTRL_RESET_BIT];
    wire logic sw_trig   = wr && paddr == lsq_pkg::CTRL_OFF && pwdata[lsq_pkg::CTRL_TRIG_BIT];
    wire logic any_trig  = sw_trig || trig_s_ff;

    // ==========================================================
    // List loading; each write sets the one entry at its index
    logic [6:0] nxt_vlen, nxt_slen, nxt_elen;
    always_comb begin
        nxt_vlen = vlen_ff;
        nxt_slen = slen_ff;
        nxt_elen = elen_ff;
        if (cmd_rst) begin
            nxt_vlen = 7'd1;
            nxt_slen = 7'd1;
            nxt_elen = 7'd1;
        end else if (wr && paddr == lsq_pkg::LEN_OFF) begin
            // Lengths set whole; zero or oversize refused
            if (pwdata[6:0] != 7'd0 && pwdata[6:0] <= 7'(STEPS)) nxt_vlen = pwdata[6:0];
            if (pwdata[14:8] != 7'd0 && pwdata[14:8] <= 7'(STEPS)) nxt_slen = pwdata[14:8];
            if (pwdata[22:16] != 7'd0 && pwdata[22:16] <= 7'(STEPS)) nxt_elen = pwdata[22:16];
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            vlen_ff <= 7'd1;
            slen_ff <= 7'd1;
            elen_ff <= 7'd1;
            start_flags_ff <= '0;
            end_flags_ff <= '0;
            dwell_ms_ff <= 22'(lsq_pkg::DWELL_MIN_MS);
            paced_ff <= 1'b0;
            hold_ff <= 1'b0;
            rd_idx_ff <= 7'd0;
        end else begin
            vlen_ff <= nxt_vlen;
            slen_ff <= nxt_slen;
            elen_ff <= nxt_elen;
            if (cmd_rst) begin
                start_flags_ff <= '0;
                end_flags_ff <= '0;
            end else if (wr && paddr == lsq_pkg::LOAD_OFF && ld_idx < 7'(STEPS)) begin
                // Entry index is the step number
                start_flags_ff[ld_idx] <= pwdata[lsq_pkg::LOAD_START_BIT];
                end_flags_ff[ld_idx] <= pwdata[lsq_pkg::LOAD_END_BIT];
            end
            if (wr && paddr == lsq_pkg::DWELL_OFF) dwell_ms_ff <= pwdata[21:0];
            if (wr && paddr == lsq_pkg::READ_IDX_OFF) rd_idx_ff <= pwdata[6:0];
            if (wr && paddr == lsq_pkg::CTRL_OFF) begin
                paced_ff <= pwdata[lsq_pkg::CTRL_PACED_BIT];
                hold_ff <= pwdata[lsq_pkg::CTRL_HOLD_BIT];
            end
        end
    end

    // Voltage memory, no reset on the array
    always_ff @(posedge clock) begin
        if (cmd_rst) volt_mem[0] <= lsq_pkg::VOLT_MIN;
        else if (wr && paddr == lsq_pkg::LOAD_OFF && ld_idx < 7'(STEPS))
            volt_mem[ld_idx] <= pwdata[15:0];
    end

    // ==========================================================
    // Step engine
    lsq_pkg::lsq_state_t state_ff, nxt_state;
    logic [6:0]  step_ff, nxt_step;
    logic [21:0] ms_ff, nxt_ms;
    logic [31:0] cyc_ff, nxt_cyc;
    logic [15:0] nxt_volt;
    logic        nxt_trig, nxt_run;
    logic        held_ff, nxt_held;      // Output kept at the last step

    wire logic ms_tick  = cyc_ff == 32'(MS_CYC - 1);
    wire logic dwell_end = ms_tick && (ms_ff + 22'd1 >= dwell_ms_ff);
    wire logic last_step = step_ff + 7'd1 >= run_len;
    wire logic end_flag  = end_flags_ff[pick(elen_ff, step_ff)];

    always_comb begin
        nxt_state = state_ff;
        nxt_step = step_ff;
        nxt_ms = ms_ff;
        nxt_cyc = cyc_ff;
        nxt_volt = volt_out_ff;
        nxt_trig = 1'b0;
        nxt_run = running_ff;
        nxt_held = held_ff;
        case (state_ff)
            lsq_pkg::LSQ_IDLE: begin
                // A held last step stays until the next start, abort or list reset
                if (!held_ff) nxt_volt = idle_volt;
                if (cmd_start && valid && dwell_ok) begin
                    nxt_state = lsq_pkg::LSQ_DWELL;
                    nxt_held = 1'b0;
                    nxt_step = 7'd0;
                    nxt_ms = '0;
                    nxt_cyc = '0;
                    nxt_run = 1'b1;
                    nxt_volt = volt_mem[pick(vlen_ff, 7'd0)];
                    nxt_trig = start_flags_ff[pick(slen_ff, 7'd0)];
                end
            end
            lsq_pkg::LSQ_DWELL: begin
                // Triggers here are ignored
                nxt_cyc = ms_tick ? 32'd0 : cyc_ff + 32'd1;
                nxt_ms = ms_tick ? ms_ff + 22'd1 : ms_ff;
                if (dwell_end) begin
                    nxt_trig = end_flag;
                    if (paced_ff && !last_step) nxt_state = lsq_pkg::LSQ_WAIT;
                    else if (last_step) begin
                        nxt_state = lsq_pkg::LSQ_IDLE;
                        nxt_run = 1'b0;
                        // Hold keeps the last setpoint as the new setting
                        nxt_held = hold_ff;
                        if (!hold_ff) nxt_volt = idle_volt;
                    end else begin
                        nxt_step = step_ff + 7'd1;
                        nxt_ms = '0;
                        nxt_cyc = '0;
                        nxt_volt = volt_mem[pick(vlen_ff, step_ff + 7'd1)];
                        nxt_trig = end_flag | start_flags_ff[pick(slen_ff, step_ff + 7'd1)];
                    end
                end
            end
            lsq_pkg::LSQ_WAIT: begin
                if (any_trig) begin
                    nxt_state = lsq_pkg::LSQ_DWELL;
                    nxt_step = step_ff + 7'd1;
                    nxt_ms = '0;
                    nxt_cyc = '0;
                    nxt_volt = volt_mem[pick(vlen_ff, step_ff + 7'd1)];
                    nxt_trig = start_flags_ff[pick(slen_ff, step_ff + 7'd1)];
                end
            end
            default: nxt_state = lsq_pkg::LSQ_IDLE;
        endcase
        // Abort wins and restores the saved setting
        if (cmd_abort || cmd_rst) begin
            nxt_state = lsq_pkg::LSQ_IDLE;
            nxt_run = 1'b0;
            nxt_volt = idle_volt;
            nxt_trig = 1'b0;
            nxt_held = 1'b0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_ff <= lsq_pkg::LSQ_IDLE;
            step_ff <= '0;
            ms_ff <= '0;
            cyc_ff <= '0;
            volt_out_ff <= lsq_pkg::VOLT_MIN;
            step_trig_ff <= 1'b0;
            running_ff <= 1'b0;
            held_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            step_ff <= nxt_step;
            ms_ff <= nxt_ms;
            cyc_ff <= nxt_cyc;
            volt_out_ff <= nxt_volt;
            step_trig_ff <= nxt_trig;
            running_ff <= nxt_run;
            held_ff <= nxt_held;
        end
    end

    // ==========================================================
    // APB read path; one wait state, unmapped reads zero with error
    logic [31:0] nxt_rd;
    logic        nxt_err;
    always_comb begin
        nxt_rd = '0;
        nxt_err = 1'b0;
        case (paddr)
            lsq_pkg::CTRL_OFF: nxt_rd = {30'd0, hold_ff, paced_ff};
            lsq_pkg::STATUS_OFF: nxt_rd = {16'd0, 1'b0, step_ff, 5'd0, valid,
                                          state_ff == lsq_pkg::LSQ_WAIT, running_ff};
            // Counts, not values
            lsq_pkg::LEN_OFF: nxt_rd = {9'd0, elen_ff, 1'b0, slen_ff, 1'b0, vlen_ff};
            lsq_pkg::LEN_SEL_OFF: nxt_rd = {25'd0, vlen_ff};
            lsq_pkg::DWELL_OFF: nxt_rd = {10'd0, dwell_ms_ff};
            lsq_pkg::READ_IDX_OFF: nxt_rd = {25'd0, rd_idx_ff};
            lsq_pkg::READ_OFF: if (rd_idx_ff < 7'(STEPS))
                // Flags read as 0 or 1 per step
                nxt_rd = {14'd0, end_flags_ff[rd_idx_ff], start_flags_ff[rd_idx_ff],
                          volt_mem[rd_idx_ff]};
            lsq_pkg::LOAD_OFF: nxt_rd = '0;
            default: nxt_err = 1'b1;
        endcase
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            prdata_ff <= '0;
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
        end else begin
            pready_ff <= psel && penable && !pready_ff;
            prdata_ff <= (acc && !pwrite) ? nxt_rd : prdata_ff;
            pslverr_ff <= acc && nxt_err;
        end
    end
    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;

    // ==========================================================
    // Checks
    a_reset_len_one: assert property (@(posedge clock) disable iff (reset)
        cmd_rst |=> vlen_ff == 7'd1 && slen_ff == 7'd1 && elen_ff == 7'd1)
        else $error("Lists not one entry after reset command");
    a_abort_restores: assert property (@(posedge clock) disable iff (reset)
        cmd_abort |=> !running_ff && volt_out_ff == $past(idle_volt))
        else $error("Abort did not restore output");
    a_hold_keeps: assert property (@(posedge clock) disable iff (reset)
        state_ff == lsq_pkg::LSQ_IDLE && held_ff && !cmd_start && !cmd_abort && !cmd_rst
        |=> $stable(volt_out_ff))
        else $error("Held setpoint changed while idle");
    a_wait_holds: assert property (@(posedge clock) disable iff (reset)
        state_ff == lsq_pkg::LSQ_WAIT && !any_trig && !cmd_abort && !cmd_rst
        |=> $stable(step_ff))
        else $error("Step advanced without trigger");
    a_start_trig: assert property (@(posedge clock) disable iff (reset)
        state_ff == lsq_pkg::LSQ_IDLE && cmd_start && valid && dwell_ok && !cmd_abort
        && !cmd_rst |=> step_trig_ff == start_flags_ff[pick(slen_ff, 7'd0)])
        else $error("Start trigger mismatch");
    a_trig_pulse: assert property (@(posedge clock) disable iff (reset)
        step_trig_ff |-> running_ff || $past(running_ff))
        else $error("Trigger outside list run");
    a_invalid_nostart: assert property (@(posedge clock) disable iff (reset)
        state_ff == lsq_pkg::LSQ_IDLE && !valid |=> !running_ff)
        else $error("Invalid list started");
    a_dwell_step: assert property (@(posedge clock) disable iff (reset)
        state_ff == lsq_pkg::LSQ_DWELL && dwell_end && !paced_ff && !last_step
        && !cmd_abort && !cmd_rst |=> step_ff == $past(step_ff) + 7'd1)
        else $error("Dwell-paced step not advanced");
    a_len_read: assert property (@(posedge clock) disable iff (reset)
        acc && !pwrite && paddr == lsq_pkg::LEN_SEL_OFF
        |=> prdata_ff == {25'd0, $past(vlen_ff)})
        else $error("Length readback wrong");
    // Main scenarios: pulses in a run, a paced wait, an abort, a held end
    c_run: cover property (@(posedge clock) running_ff && step_trig_ff);
    c_wait: cover property (@(posedge clock) state_ff == lsq_pkg::LSQ_WAIT && any_trig);
    c_abort: cover property (@(posedge clock) running_ff && cmd_abort);
    c_hold: cover property (@(posedge clock) held_ff && state_ff == lsq_pkg::LSQ_IDLE);
endmodule

// >>> rtl/lsq_pkg.sv
package lsq_pkg;
    // ==========================================================
    // Register map (APB byte addresses)
    localparam logic [7:0] CTRL_OFF     = 8'h00; // Control and commands
    localparam logic [7:0] STATUS_OFF   = 8'h04; // Run state, step index and valid flag
    localparam logic [7:0] LOAD_OFF     = 8'h08; // Step load window
    localparam logic [7:0] LEN_OFF      = 8'h0c; // List lengths
    localparam logic [7:0] DWELL_OFF    = 8'h10; // Dwell in milliseconds
    localparam logic [7:0] READ_IDX_OFF = 8'h14; // Readback index
    localparam logic [7:0] READ_OFF     = 8'h18; // Readback data
    localparam logic [7:0] LEN_SEL_OFF  = 8'h1c; // Selected channel length

    // ==========================================================
    // Control bit positions
    localparam int CTRL_PACED_BIT = 0;  // trigger_paced
    localparam int CTRL_HOLD_BIT  = 1;  // hold_last_step
    localparam int CTRL_START_BIT = 2;  // Start pulse
    localparam int CTRL_ABORT_BIT = 3;  // Abort pulse
    localparam int CTRL_RESET_BIT = 4;  // Reset lists pulse
    localparam int CTRL_TRIG_BIT  = 5;  // Software trigger

    // ==========================================================
    // Load word layout: [15:0] volts, [16] start flag, [17] end flag, [30:24] index
    localparam int LOAD_START_BIT = 16;
    localparam int LOAD_END_BIT   = 17;
    localparam int LOAD_IDX_LSB   = 24;

    // ==========================================================
    // Defaults and timing
    localparam logic [15:0] VOLT_MIN      = 16'h0000; // Minimum setpoint code
    localparam int          MAX_STEPS     = 100;
    localparam int          CLOCK_HZ      = 50_000_000;
    localparam int          MS_PER_S      = 1000;
    localparam int          CYC_PER_MS    = CLOCK_HZ / MS_PER_S;
    localparam int          DWELL_MIN_MS  = 10;       // 0.01 s
    localparam int          DWELL_MAX_MS  = 3_600_000; // 3600 s

    typedef enum logic [1:0] {LSQ_IDLE, LSQ_DWELL, LSQ_WAIT} lsq_state_t;
endpackage

// >>> sim/lsq_apb_master.sv
// ==========================================================
// Remote controller side: an APB master issuing register commands
module lsq_apb_master (
    // Clock
    input  wire logic        clock,
    // APB request
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [7:0]  paddr,
    output logic      [31:0] pwdata,
    // APB answer
    input  wire logic [31:0] prdata,
    input  wire logic        pready,
    input  wire logic        pslverr
);
    timeunit 1ns;
    timeprecision 1ns;

    // Idle bus at time zero
    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 8'h00;
        pwdata  = 32'h0000_0000;
    end

    // ==========================================================
    // One transfer: setup, access, hold until pready seen high
    task automatic xfer(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                        output logic [31:0] rd, output logic err);
        @(posedge clock);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= data;
        @(posedge clock);
        penable <= 1'b1;
        // Wait as long as the slave needs; only the bench watchdog ends a hang
        do begin
            @(posedge clock);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data no longer shows the old value
        pwdata  <= ~data;
    endtask
endmodule

// >>> sim/tb_list_step_trigger_sequencer.sv
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin num_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, (a), (b)); end end

module tb_list_step_trigger_sequencer;
    timeunit 1ns;
    timeprecision 1ns;

    // ==========================================================
    // Setup
    localparam int MSC      = 2;         // Short millisecond keeps runs brief
    localparam int STEP_CYC = 10 * MSC;  // Cycles of one 10 ms dwell
    logic        clock, reset, psel, penable, pwrite, pready, pslverr, ext_trig;
    logic        step_trig_ff, running_ff;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdat;
    logic [15:0] idle_volt, volt_out_ff, last_v;
    logic [15:0] volts[100];  // Expected setpoints
    logic        sf[100];     // Expected start flags
    logic        ef[100];     // Expected end flags
    logic [15:0] vlog[$];     // Output setpoint history
    int          num_errors, tests_run, trig_count, n, sl, w;

    lsq_sequencer #(.STEPS(100), .MS_CYC(MSC)) u_dut (
        .clock(clock), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .idle_volt(idle_volt), .ext_trig(ext_trig),
        .volt_out_ff(volt_out_ff), .step_trig_ff(step_trig_ff), .running_ff(running_ff));

    lsq_apb_master u_mst (
        .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

    // Clock generator
    always #10 clock = ~clock;

    // Monitor: counts trigger pulses, logs every setpoint change
    always @(posedge clock) begin
        if (step_trig_ff === 1'b1) trig_count++;
        if (volt_out_ff !== last_v) begin
            vlog.push_back(volt_out_ff);
            last_v = volt_out_ff;
        end
    end

    // ==========================================================
    // Helpers
    task automatic close_out;
        if (num_errors == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic e;
        u_mst.xfer(1'b1, a, d, rdat, e);
    endtask

    // Read and compare, unmapped places must answer with an error
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic e;
        u_mst.xfer(1'b0, a, 32'h0, rdat, e);
        `CHK(rdat, exp)
        `CHK(e, 1'(a > lsq_pkg::LEN_SEL_OFF))
    endtask

    task automatic pulse_trig;
        ext_trig <= 1'b1;
        repeat (2) @(posedge clock);
        ext_trig <= 1'b0;
    endtask

    // Start flag of next step merges with end flag of the one before
    function automatic int exp_pulses(int cnt, int slen);
        int c = 0;
        for (int i = 0; i <= cnt; i++) begin
            c += int'((i < cnt && sf[slen == 1 ? 0 : i]) || (i > 0 && ef[i - 1]));
        end
        return c;
    endfunction

    // Watchdog sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge clock);
        num_errors++;
        close_out();
    end

    // ==========================================================
    // Main sequence
    initial begin
        clock = 1'b0;
        reset = 1'b1;
        ext_trig = 1'b0;
        num_errors = 0;
        tests_run = 0;
        void'($urandom(32'hea42));
        idle_volt = {4'h0, 12'($urandom)};
        repeat (20) @(posedge clock);
        reset <= 1'b0;
        wr(lsq_pkg::CTRL_OFF, 32'h10);
        rd_chk(lsq_pkg::LEN_OFF, 32'h0001_0101);
        rd_chk(lsq_pkg::LEN_SEL_OFF, 32'h1);
        wr(lsq_pkg::READ_IDX_OFF, 32'h0);
        rd_chk(lsq_pkg::READ_OFF, {16'h0, lsq_pkg::VOLT_MIN});
        rd_chk(8'h20, 32'h0);
        // Two auto runs: full flag list without hold, then single start flag with hold
        for (int r = 0; r < 2; r++) begin
            n = (r == 0) ? 3 + int'($urandom % 3) : 2;
            sl = (r == 0) ? n : 1;
            for (int i = 0; i < n; i++) begin
                volts[i] = {4'(i + 1), 12'($urandom)};
                sf[i] = 1'($urandom);
                ef[i] = 1'($urandom);
                wr(lsq_pkg::LOAD_OFF, {1'b0, 7'(i), 6'h0, ef[i], sf[i], volts[i]});
            end
            wr(lsq_pkg::LEN_OFF, {9'h0, 7'(n), 1'b0, 7'(sl), 1'b0, 7'(n)});
            rd_chk(lsq_pkg::LEN_OFF, {9'h0, 7'(n), 1'b0, 7'(sl), 1'b0, 7'(n)});
            rd_chk(lsq_pkg::LEN_SEL_OFF, 32'(n));
            for (int i = 0; i < n; i++) begin
                wr(lsq_pkg::READ_IDX_OFF, 32'(i));
                rd_chk(lsq_pkg::READ_OFF, {14'h0, ef[i], sf[i], volts[i]});
            end
            @(negedge clock);
            trig_count = 0;
            vlog.delete();
            wr(lsq_pkg::CTRL_OFF, (r == 1) ? 32'h6 : 32'h4);
            repeat (2) @(posedge clock);
            w = 0;
            while (running_ff === 1'b1 && w < n * STEP_CYC + 40) begin
                @(posedge clock);
                w++;
            end
            repeat (3) @(posedge clock);
            `CHK(trig_count, exp_pulses(n, sl))
            `CHK(vlog.size(), n + 1 - r)
            for (int i = 0; i < n; i++) `CHK(vlog[i], volts[i])
            `CHK(volt_out_ff, (r == 1) ? volts[n - 1] : idle_volt)
        end
        // Paced run: trigger inside dwell ignored, trigger while waiting advances
        wr(lsq_pkg::CTRL_OFF, 32'h5);
        repeat (3) @(posedge clock);
        pulse_trig();
        repeat (3 * STEP_CYC) @(posedge clock);
        rd_chk(lsq_pkg::STATUS_OFF, 32'h7);
        pulse_trig();
        repeat (8) @(posedge clock);
        rd_chk(lsq_pkg::STATUS_OFF, 32'h105);
        wr(lsq_pkg::CTRL_OFF, 32'h9);
        repeat (2) @(posedge clock);
        `CHK(running_ff, 1'b0)
        `CHK(volt_out_ff, idle_volt)
        // Length refusals, full-size list, mismatched lengths
        wr(lsq_pkg::LEN_OFF, 32'h0);
        rd_chk(lsq_pkg::LEN_OFF, 32'h0002_0102);
        wr(lsq_pkg::LEN_OFF, 32'h0001_0264);
        rd_chk(lsq_pkg::LEN_OFF, 32'h0001_0264);
        // Step index keeps its last value (1) after the abort above
        rd_chk(lsq_pkg::STATUS_OFF, 32'h100);
        wr(lsq_pkg::LEN_OFF, 32'h0001_0164);
        rd_chk(lsq_pkg::STATUS_OFF, 32'h104);
        // Dwell range edges: just below refused, maximum accepted
        wr(lsq_pkg::DWELL_OFF, 32'(lsq_pkg::DWELL_MIN_MS - 1));
        wr(lsq_pkg::CTRL_OFF, 32'h4);
        repeat (3) @(posedge clock);
        `CHK(running_ff, 1'b0)
        wr(lsq_pkg::DWELL_OFF, 32'(lsq_pkg::DWELL_MAX_MS));
        wr(lsq_pkg::CTRL_OFF, 32'h4);
        repeat (3) @(posedge clock);
        `CHK(running_ff, 1'b1)
        wr(lsq_pkg::CTRL_OFF, 32'h8);
        repeat (2) @(posedge clock);
        `CHK(running_ff, 1'b0)
        close_out();
    end
endmodule
